// ==== include/tmr_pkg.sv ====
package tmr_pkg;
    // Special function register addresses of the timer.
    localparam logic [7:0] ADDR_CONTROL   = 8'hC8;
    localparam logic [7:0] ADDR_MODE      = 8'hC9;
    localparam logic [7:0] ADDR_RELOAD_LO = 8'hCA;
    localparam logic [7:0] ADDR_RELOAD_HI = 8'hCB;
    localparam logic [7:0] ADDR_COUNT_LO  = 8'hCC;
    localparam logic [7:0] ADDR_COUNT_HI  = 8'hCD;

    // Control register bit positions.
    localparam int BIT_OVF     = 7;
    localparam int BIT_EXF     = 6;
    localparam int BIT_RXBAUD  = 5;
    localparam int BIT_TXBAUD  = 4;
    localparam int BIT_EXEN    = 3;
    localparam int BIT_RUN     = 2;
    localparam int BIT_CNTSEL  = 1;
    localparam int BIT_CAPSEL  = 0;

    // Mode register bit positions.
    localparam int BIT_AUTOCLR = 3;
    localparam int BIT_DOWN_COUNT_ENABLE    = 0;

    // Reset value and mode register readback mask.
    localparam logic [7:0] RST_BYTE    = 8'h00;
    localparam logic [7:0] MODE_RD_MSK = 8'h09;

    // Baud mode advances once per this many system clocks.
    localparam int BAUD_DIV = 2;
    // Timer mode prescale divisors selected by the clock control bit.
    localparam int PRESCALE_SLOW = 12;
    localparam int PRESCALE_FAST = 4;
endpackage : tmr_pkg

// ==== hdl/tmr_edge_sync.sv ====
`timescale 1ns/1ps
// Two-stage synchroniser with level and falling-edge outputs.
module tmr_edge_sync (
    input  wire logic mclk,
    input  wire logic rst_b,
    input  wire logic pin,
    output logic      level,
    output logic      fall
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            prev_q <= 1'b1;
        end else begin
            meta_q <= pin;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign fall  = prev_q & ~sync_q;
endmodule : tmr_edge_sync

// ==== hdl/tmr_timer2.sv ====
`timescale 1ns/1ps
module tmr_timer2 (
    input  wire logic       mclk,
    input  wire logic       rst_b,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_wr,
    output logic      [7:0] sfr_rdata,
    input  wire logic       timer_prescale_select,
    input  wire logic       timer_irq_enable,
    input  wire logic       other_timer_overflow,
    input  wire logic       count_input_pin,
    input  wire logic       ext_trigger_pin,
    output logic            timer_irq,
    output logic            rx_baud_tick,
    output logic            tx_baud_tick,
    output logic            overflow_pulse
);
    logic [7:0] control_q;
    logic [7:0] mode_q;
    logic [7:0] reload_lo_q;
    logic [7:0] reload_hi_q;
    logic [7:0] count_lo_q;
    logic [7:0] count_hi_q;
    logic [3:0] prescale_q;
    logic       irq_q;
    logic       rx_tick_q;
    logic       tx_tick_q;
    logic       ovf_pulse_q;

    logic       trig_level;
    logic       trig_fall;
    logic       cnt_fall;

    tmr_edge_sync u_trig_sync (
        .mclk  (mclk),
        .rst_b (rst_b),
        .pin   (ext_trigger_pin),
        .level (trig_level),
        .fall  (trig_fall)
    );

    tmr_edge_sync u_cnt_sync (
        .mclk  (mclk),
        .rst_b (rst_b),
        .pin   (count_input_pin),
        .level (),
        .fall  (cnt_fall)
    );

    // Field decode.
    wire rx_sel    = control_q[tmr_pkg::BIT_RXBAUD];
    wire tx_sel    = control_q[tmr_pkg::BIT_TXBAUD];
    wire ext_en    = control_q[tmr_pkg::BIT_EXEN];
    wire run       = control_q[tmr_pkg::BIT_RUN];
    wire cnt_sel   = control_q[tmr_pkg::BIT_CNTSEL];
    wire cap_sel   = control_q[tmr_pkg::BIT_CAPSEL];
    wire auto_clr  = mode_q[tmr_pkg::BIT_AUTOCLR];
    wire down_count_enable      = mode_q[tmr_pkg::BIT_DOWN_COUNT_ENABLE];

    wire baud_mode = rx_sel | tx_sel;
    wire capture_mode = cap_sel & ~baud_mode;
    wire reload_mode  = ~capture_mode;

    // Register strobes.
    wire wr_ctl = sfr_wr && (sfr_addr == tmr_pkg::ADDR_CONTROL);
    wire wr_mod = sfr_wr && (sfr_addr == tmr_pkg::ADDR_MODE);
    wire wr_rlo = sfr_wr && (sfr_addr == tmr_pkg::ADDR_RELOAD_LO);
    wire wr_rhi = sfr_wr && (sfr_addr == tmr_pkg::ADDR_RELOAD_HI);
    wire wr_clo = sfr_wr && (sfr_addr == tmr_pkg::ADDR_COUNT_LO);
    wire wr_chi = sfr_wr && (sfr_addr == tmr_pkg::ADDR_COUNT_HI);

    // Tick generation: baud mode ignores the counter select and prescaler.
    wire [3:0] prescale_top = timer_prescale_select ?
                              4'(tmr_pkg::PRESCALE_FAST - 1) :
                              4'(tmr_pkg::PRESCALE_SLOW - 1);
    wire [3:0] div_top = baud_mode ? 4'(tmr_pkg::BAUD_DIV - 1) : prescale_top;
    wire       div_wrap = (prescale_q == div_top);
    wire       use_pin  = cnt_sel & ~baud_mode;
    wire       tick     = run & (use_pin ? cnt_fall : div_wrap);

    // Direction: up unless down counting is enabled in reload mode outside baud mode with pin low.
    wire       count_down = down_count_enable & reload_mode & ~baud_mode & ~trig_level;

    wire [15:0] count   = {count_hi_q, count_lo_q};
    wire [15:0] reload  = {reload_hi_q, reload_lo_q};
    wire        up_ovf  = tick & ~count_down & (count == 16'hFFFF);
    wire        dn_ovf  = tick & count_down & (count == reload);
    wire        ovf     = up_ovf | dn_ovf;

    // Trigger edge is honoured only outside baud mode with the enable set.
    wire        trig_ev = trig_fall & ext_en & ~baud_mode;
    wire        do_cap  = trig_ev & capture_mode;
    wire        trig_rl = trig_ev & reload_mode & ~down_count_enable;

    // Next count value.
    logic [15:0] count_d;
    always_comb begin
        count_d = count;
        if (tick) begin
            count_d = count_down ? count - 16'h0001 : count + 16'h0001;
        end
        if (up_ovf && reload_mode) begin
            count_d = reload;
        end
        if (dn_ovf) begin
            count_d = 16'hFFFF;
        end
        if (trig_rl) begin
            count_d = reload;
        end
        if (do_cap && auto_clr) begin
            count_d = 16'h0000;
        end
    end

    // Flag next values; hardware sets win over a software clear in the same cycle.
    wire ovf_set = ovf & ~baud_mode;
    // With down counting enabled in reload mode outside baud mode, every overflow, up or down, marks the external flag.
    wire exf_set = trig_ev | (ovf & down_count_enable & reload_mode & ~baud_mode);
    wire [7:0] ctl_base = wr_ctl ? sfr_wdata : control_q;
    wire [7:0] control_d = {ctl_base[7] | ovf_set, ctl_base[6] | exf_set, ctl_base[5:0]};
    wire exf_sw_set = wr_ctl & sfr_wdata[tmr_pkg::BIT_EXF] & ~control_q[tmr_pkg::BIT_EXF];

    // Hardware flag sets are already folded into control_d, so one flop holds both.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            control_q <= tmr_pkg::RST_BYTE;
        end else begin
            control_q <= control_d;
        end
    end

    // Unused mode bits are dropped on write, so they always read back as zero.
    wire [7:0] mode_d = wr_mod ? (sfr_wdata & tmr_pkg::MODE_RD_MSK) : mode_q;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            mode_q <= tmr_pkg::RST_BYTE;
        end else begin
            mode_q <= mode_d;
        end
    end

    // A capture wins over a software write to the same byte in the same cycle.
    wire [7:0] reload_lo_d = do_cap ? count_lo_q : (wr_rlo ? sfr_wdata : reload_lo_q);
    wire [7:0] reload_hi_d = do_cap ? count_hi_q : (wr_rhi ? sfr_wdata : reload_hi_q);

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            reload_lo_q <= tmr_pkg::RST_BYTE;
        end else begin
            reload_lo_q <= reload_lo_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            reload_hi_q <= tmr_pkg::RST_BYTE;
        end else begin
            reload_hi_q <= reload_hi_d;
        end
    end

    // Software writes to the count bytes take priority over counting.
    // A write to one byte lets the other byte keep counting, so software
    // should stop the timer before loading a full sixteen-bit value.
    wire [7:0] count_lo_d = wr_clo ? sfr_wdata : count_d[7:0];
    wire [7:0] count_hi_d = wr_chi ? sfr_wdata : count_d[15:8];

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            count_lo_q <= tmr_pkg::RST_BYTE;
        end else begin
            count_lo_q <= count_lo_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            count_hi_q <= tmr_pkg::RST_BYTE;
        end else begin
            count_hi_q <= count_hi_d;
        end
    end

    // The divider keeps running while stopped so restart phase is arbitrary.
    // A switch to a shorter period can leave it above the top, hence the div_over test.
    wire       div_over   = (prescale_q > div_top);
    wire [3:0] prescale_d = (div_wrap || div_over) ? 4'h0 : prescale_q + 4'h1;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            prescale_q <= 4'h0;
        end else begin
            prescale_q <= prescale_d;
        end
    end

    // Serial time bases in serial modes 1 and 3.
    wire rx_src = rx_sel ? ovf : other_timer_overflow;
    wire tx_src = tx_sel ? ovf : other_timer_overflow;

    wire flags_any = control_d[tmr_pkg::BIT_OVF] | control_d[tmr_pkg::BIT_EXF];
    wire irq_d     = timer_irq_enable & (flags_any | exf_sw_set | trig_ev);

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rx_tick_q <= 1'b0;
        end else begin
            rx_tick_q <= rx_src;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            tx_tick_q <= 1'b0;
        end else begin
            tx_tick_q <= tx_src;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ovf_pulse_q <= 1'b0;
        end else begin
            ovf_pulse_q <= ovf;
        end
    end

    // Read mux, registered so the data follows the address by one clock.
    // Unmapped addresses read as zero because no select is active.
    logic [7:0] rdata_q;
    wire        sel_ctl = (sfr_addr == tmr_pkg::ADDR_CONTROL);
    wire        sel_mod = (sfr_addr == tmr_pkg::ADDR_MODE);
    wire        sel_rlo = (sfr_addr == tmr_pkg::ADDR_RELOAD_LO);
    wire        sel_rhi = (sfr_addr == tmr_pkg::ADDR_RELOAD_HI);
    wire        sel_clo = (sfr_addr == tmr_pkg::ADDR_COUNT_LO);
    wire        sel_chi = (sfr_addr == tmr_pkg::ADDR_COUNT_HI);
    wire  [7:0] rd_mux  = ({8{sel_ctl}} & control_q) |
                          ({8{sel_mod}} & mode_q) |
                          ({8{sel_rlo}} & reload_lo_q) |
                          ({8{sel_rhi}} & reload_hi_q) |
                          ({8{sel_clo}} & count_lo_q) |
                          ({8{sel_chi}} & count_hi_q);

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rd_mux;
        end
    end

    assign sfr_rdata      = rdata_q;
    assign timer_irq      = irq_q;
    assign rx_baud_tick   = rx_tick_q;
    assign tx_baud_tick   = tx_tick_q;
    assign overflow_pulse = ovf_pulse_q;
endmodule : tmr_timer2

// ==== verif/tmr_timer2_props.sv ====
`timescale 1ns/1ps
module tmr_timer2_props (
    input wire logic       mclk,
    input wire logic       rst_b,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic       sfr_wr,
    input wire logic [7:0] sfr_rdata,
    input wire logic       timer_irq_enable,
    input wire logic       other_timer_overflow,
    input wire logic       timer_irq,
    input wire logic       rx_baud_tick,
    input wire logic       tx_baud_tick
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    logic [7:0] ctl_q;
    wire        at_ctl = sfr_addr == tmr_pkg::ADDR_CONTROL;
    wire        no_en  = !timer_irq_enable;
    wire        idle   = sfr_addr == tmr_pkg::ADDR_COUNT_LO && !sfr_wr && ctl_q[5:2] == 4'h0;
    wire        baud   = at_ctl && !sfr_wr && (ctl_q[5] || ctl_q[4]);
    // Baud, run and enable bits change only by software, so a write shadow tracks them.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ctl_q <= 8'h00;
        end else if (sfr_wr && at_ctl) begin
            ctl_q <= sfr_wdata;
        end
    end
    a_irq_needs_en: assert property (no_en && $past(no_en) |-> !timer_irq)
        else $error("interrupt raised while disabled");
    a_irq_held_set: assert property (timer_irq && !no_en && !sfr_wr |=> timer_irq)
        else $error("interrupt dropped without a clear");
    a_irq_on_write: assert property (sfr_wr && at_ctl && sfr_wdata[6] && !no_en ##1 !no_en
        |-> ##[0:1] timer_irq)
        else $error("flag write gave no interrupt");
    a_rx_other_tick: assert property (!ctl_q[5] |=> rx_baud_tick == $past(other_timer_overflow))
        else $error("receive tick not from other timer");
    a_tx_other_tick: assert property (!ctl_q[4] |=> tx_baud_tick == $past(other_timer_overflow))
        else $error("transmit tick not from other timer");
    a_count_held_stop: assert property ($past(idle) && sfr_addr == tmr_pkg::ADDR_COUNT_LO
        |=> $stable(sfr_rdata))
        else $error("count moved while stopped");
    a_baud_no_ovf: assert property ($past(baud) && at_ctl |=> !$rose(sfr_rdata[7]))
        else $error("overflow flag set in baud mode");
    a_mode_readback: assert property (sfr_wr && sfr_addr == tmr_pkg::ADDR_MODE ##1 !sfr_wr
        && sfr_addr == tmr_pkg::ADDR_MODE |=> sfr_rdata
        == ($past(sfr_wdata, 2) & tmr_pkg::MODE_RD_MSK))
        else $error("mode register readback wrong");
    c_irq: cover property (timer_irq);
    c_rx_own: cover property (ctl_q[5] && rx_baud_tick);
    c_tx_own: cover property (ctl_q[4] && tx_baud_tick);
endmodule : tmr_timer2_props
bind tmr_timer2 tmr_timer2_props props_u (.mclk(mclk), .rst_b(rst_b), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rdata(sfr_rdata),
    .timer_irq_enable(timer_irq_enable), .other_timer_overflow(other_timer_overflow),
    .timer_irq(timer_irq), .rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick));

// ==== verif/tmr_core_model.sv ====
`timescale 1ns/1ps
module tmr_core_model (
    input  wire logic       mclk,
    input  wire logic [7:0] sfr_rdata,
    output logic      [7:0] sfr_addr,
    output logic      [7:0] sfr_wdata,
    output logic            sfr_wr
);
    initial begin
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge mclk);
        sfr_wr = 1'b0;
    endtask : wr
    // The read port is registered, so data is taken one cycle after the address.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        sfr_addr = a;
        @(negedge mclk);
        d = sfr_rdata;
    endtask : rd
endmodule : tmr_core_model

// ==== verif/tmr_timer2_tb.sv ====
`timescale 1ns/1ps
module tmr_timer2_tb;
    logic        mclk, rst_b, irq_en, oth, cpin, tpin, wr, irq, rxt, txt, ovf;
    logic [7:0]  addr, wd, rd, rv, c;
    logic [15:0] x;
    logic [31:0] seed = 32'h3B2A;
    int          errors, samples_checked, n_ovf, n_rx, n_tx, cyc, st;
    tmr_timer2 dut_u (.mclk(mclk), .rst_b(rst_b), .sfr_addr(addr), .sfr_wdata(wd),
        .sfr_wr(wr), .sfr_rdata(rd), .timer_prescale_select(seed[0]),
        .timer_irq_enable(irq_en), .other_timer_overflow(oth), .count_input_pin(cpin),
        .ext_trigger_pin(tpin), .timer_irq(irq), .rx_baud_tick(rxt), .tx_baud_tick(txt),
        .overflow_pulse(ovf));
    tmr_core_model core_u (.mclk(mclk), .sfr_rdata(rd), .sfr_addr(addr), .sfr_wdata(wd),
        .sfr_wr(wr));
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        core_u.rd(a, rv);
        check("register", {8'h00, rv}, {8'h00, e});
    endtask : rdc
    task automatic cnt_edge();
        cpin = 1'b0;
        repeat (4) @(negedge mclk);
        cpin = 1'b1;
        repeat (4) @(negedge mclk);
    endtask : cnt_edge
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        n_ovf += ovf;
        n_rx += rxt;
        n_tx += txt;
        if (cyc == 8000) begin
            errors++;
            report_and_stop();
        end
    end
    initial begin
        {rst_b, irq_en, oth, cpin, tpin} = 5'b00011;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        rst_b = 1'b1;
        for (int a = 'hC7; a <= 'hCD; a++) rdc(8'(a), 8'h00);
        for (int a = 'hC9; a <= 'hCE; a++) begin
            c = rnd();
            core_u.wr(8'(a), c);
            rdc(8'(a), a == 'hC9 ? c & tmr_pkg::MODE_RD_MSK : (a == 'hCE ? 8'h00 : c));
        end
        $display("test registers done");
        irq_en = 1'b1;
        core_u.wr(tmr_pkg::ADDR_MODE, 8'h00);
        for (int k = 0; k < 2; k++) begin
            c = k ? 8'h24 : 8'h14;
            x = 16'hFFF0 | 16'(rnd() & 8'h0F);
            st = 'h10000 - int'(x);
            for (int a = 0; a < 4; a++) core_u.wr(8'hCA + 8'(a), a[0] ? x[15:8] : x[7:0]);
            core_u.wr(tmr_pkg::ADDR_CONTROL, c);
            repeat (40) @(negedge mclk);
            {n_ovf, n_rx, n_tx} = '0;
            repeat (5 * st) begin
                oth = 1'b1;
                @(negedge mclk);
                oth = 1'b0;
                repeat (3) @(negedge mclk);
            end
            check("overflows", 16'(n_ovf), 16'd10);
            check("own ticks", 16'(k ? n_rx : n_tx), 16'd10);
            check("other ticks", 16'(k ? n_tx : n_rx), 16'(5 * st));
            check("irq", {15'h0, irq}, 16'h0);
            rdc(tmr_pkg::ADDR_CONTROL, c);
        end
        $display("test baud done");
        x = {rnd(), rnd()};
        core_u.wr(tmr_pkg::ADDR_CONTROL, 8'h00);
        core_u.wr(tmr_pkg::ADDR_MODE, 8'h08);
        for (int a = 0; a < 4; a++) core_u.wr(8'hCA + 8'(a), a < 2 ? 8'h00 : x[8*a-16+:8]);
        for (int k = 0; k < 2; k++) begin
            core_u.wr(tmr_pkg::ADDR_CONTROL, k ? 8'h0F : 8'h07);
            tpin = 1'b0;
            repeat (8) @(negedge mclk);
            tpin = 1'b1;
            repeat (8) @(negedge mclk);
            for (int a = 0; a < 4; a++) rdc(8'hCA + 8'(a), (a < 2) == k ? x[8*a%16+:8] : 8'h00);
            rdc(tmr_pkg::ADDR_CONTROL, k ? 8'h4F : 8'h07);
            check("irq", {15'h0, irq}, 16'(k));
        end
        irq_en = 1'b0;
        repeat (3) @(negedge mclk);
        check("irq", {15'h0, irq}, 16'h0);
        irq_en = 1'b1;
        core_u.wr(tmr_pkg::ADDR_CONTROL, 8'h0F);
        repeat (3) @(negedge mclk);
        check("irq", {15'h0, irq}, 16'h0);
        core_u.wr(tmr_pkg::ADDR_CONTROL, 8'h4B);
        repeat (3) @(negedge mclk);
        check("irq", {15'h0, irq}, 16'h1);
        $display("test capture done");
        core_u.wr(tmr_pkg::ADDR_CONTROL, 8'h00);
        core_u.wr(tmr_pkg::ADDR_MODE, 8'h01);
        for (int a = 0; a < 4; a++) core_u.wr(8'hCA + 8'(a), a[0] ? 8'h00 : (a < 2 ? 8'h10 : 8'h12));
        tpin = 1'b0;
        core_u.wr(tmr_pkg::ADDR_CONTROL, 8'h06);
        repeat (3) cnt_edge();
        rdc(tmr_pkg::ADDR_COUNT_LO, 8'hFF);
        rdc(tmr_pkg::ADDR_COUNT_HI, 8'hFF);
        rdc(tmr_pkg::ADDR_CONTROL, 8'hC6);
        check("irq", {15'h0, irq}, 16'h1);
        tpin = 1'b1;
        core_u.wr(tmr_pkg::ADDR_CONTROL, 8'h06);
        cnt_edge();
        rdc(tmr_pkg::ADDR_COUNT_LO, 8'h10);
        rdc(tmr_pkg::ADDR_COUNT_HI, 8'h00);
        rdc(tmr_pkg::ADDR_CONTROL, 8'hC6);
        $display("test reload done");
        report_and_stop();
    end
endmodule : tmr_timer2_tb
